// *** logic/csfm_pkg.sv ***
// What this block does
// RULE1 - Monitor failure moves clock to fast RC
// RULE2 - Fallback loads current select with fast RC
// RULE3 - Failure sets clock fail flag bit 3
// RULE4 - Fallback clears the switch request bit
// RULE5 - Fail event raised; fallback regardless of enable
// RULE6 - Fail irq priority and subpriority fields held
// RULE7 - Stay on fast RC until reset/switch
// RULE8 - Config 00 both on, 01 switching only
// RULE9 - Config high bit one disables both
// RULE10 - Switching off: current shows default config
// RULE11 - Switching off: request ignored, reads zero
// RULE12 - Start delay after reset or wake
// RULE13 - No monitoring until source is running
// RULE14 - Monitor timed by low power RC, watchdog untouched
// RULE15 - Primary submode fixed by configuration only
// RULE16 - Direct PLL to PLL switch refused
// RULE17 - Software unlocks, writes next, sets request
// RULE18 - Two keys back to back unlock
// RULE19 - Non key write relocks
// RULE20 - Equal current and next aborts switch
// RULE21 - Wait start-up timer, plus PLL lock for PLL targets
// RULE22 - Completion clears request, copies next to current
// RULE23 - Sleep during switch aborts it
// RULE24 - Absent source leaves request set
// RULE25 - No automatic relock after switch
// RULE26 - Failure when no edge within window
// RULE27 - Wrong second key returns detector idle
package csfm_pkg;
	// ==========================================
	// Register map
	localparam logic [7:0]  ADDR_OSC_CONTROL  = 8'h00;
	localparam logic [7:0]  ADDR_UNLOCK_KEY   = 8'h04;
	localparam logic [7:0]  ADDR_IRQ_CONFIG   = 8'h08;
	localparam logic [7:0]  ADDR_STATUS       = 8'h0c;
	localparam logic [31:0] KEY_FIRST         = 32'haa996655;
	localparam logic [31:0] KEY_SECOND        = 32'h556699aa;
	// ==========================================
	// Field positions
	localparam int          POS_REQUEST       = 0;
	localparam int          POS_FAIL_FLAG     = 3;
	localparam int          POS_NEXT_LO       = 8;
	localparam int          POS_CUR_LO        = 12;
	localparam int          POS_IRQ_EN        = 14;
	localparam int          POS_SUBPRIO_LO    = 8;
	localparam int          POS_PRIO_LO       = 10;
	localparam int          POS_CFG_HI        = 15;
	// ==========================================
	// Source codes
	localparam logic [2:0]  SRC_FAST_RC       = 3'h0;
	localparam logic [2:0]  SRC_FAST_RC_PLL   = 3'h1;
	localparam logic [2:0]  SRC_PRIMARY       = 3'h2;
	localparam logic [2:0]  SRC_PRIMARY_PLL   = 3'h3;
	localparam logic [2:0]  SRC_SECONDARY     = 3'h4;
	localparam logic [2:0]  SRC_LOW_POWER_RC  = 3'h5;
	// ==========================================
	// Timing
	localparam int          CLK_HZ            = 25000000;
	localparam int          MON_WINDOW_TICKS  = 4;
	localparam int          START_DELAY_TICKS = 8;
	// ==========================================
	// Carriers
	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} csfm_wb_req_type;

	typedef struct packed {
		logic       ack;
		logic [31:0] dat;
	} csfm_wb_rsp_type;

	typedef enum {
		SW_IDLE,
		SW_WAIT_READY,
		SW_DONE
	} csfm_sw_state_type;

	typedef enum {
		KEY_LOCKED,
		KEY_HALF,
		KEY_OPEN
	} csfm_key_state_type;

	typedef struct packed {
		csfm_wb_rsp_type    rsp;
		csfm_sw_state_type  sw;
		csfm_key_state_type key;
		logic               booted;
		logic [2:0]         cur_sel;
		logic [2:0]         next_sel;
		logic               request;
		logic               fail_flag;
		logic               irq_enable;
		logic               irq_flag;
		logic [2:0]         prio;
		logic [1:0]         subprio;
		logic [2:0]         low_power_rc_osc_sync;
		logic [2:0]         mon_sync;
		logic [3:0]         delay_cnt;
		logic [3:0]         win_cnt;
		logic               seen_edge;
		logic               mon_armed;
		logic [5:0]         osc_en;
		logic               irq_line;
	} csfm_state_type;
endpackage : csfm_pkg

// *** logic/csfm_core.sv ***
`timescale 1ns/1ps
module csfm_core (
	input  wire logic                     sys_clk_i,
	input  wire logic                     rst_n_i,
	input  wire csfm_pkg::csfm_wb_req_type wb_req_i,
	output csfm_pkg::csfm_wb_rsp_type      wb_rsp_o,
	input  wire logic [1:0]               switch_monitor_config_i,
	input  wire logic [2:0]               default_osc_config_i,
	input  wire logic                     low_power_rc_osc_i,
	input  wire logic                     primary_osc_i,
	input  wire logic                     primary_running_i,
	input  wire logic [5:0]               osc_ready_i,
	input  wire logic                     pll_lock_status_i,
	input  wire logic                     sleep_i,
	input  wire logic                     wake_i,
	output logic [2:0]                    current_osc_sel_o,
	output logic [5:0]                    osc_enable_o,
	output logic                          fail_irq_o,
	output logic                          fail_irq_flag_o
);
	import csfm_pkg::*;

	csfm_state_type r;
	csfm_state_type next_r;

	// PLL based source test
	function automatic logic is_pll(input logic [2:0] s);
		is_pll = (s == SRC_FAST_RC_PLL) || (s == SRC_PRIMARY_PLL);
	endfunction : is_pll

	// Crystal or secondary source test
	function automatic logic needs_delay(input logic [2:0] s);
		needs_delay = (s == SRC_PRIMARY) || (s == SRC_PRIMARY_PLL) || (s == SRC_SECONDARY);
	endfunction : needs_delay

	logic sw_en;
	logic mon_en;
	logic low_power_rc_osc_tick;
	logic mon_edge;
	logic bus_hit;
	logic wr_ok;
	logic [31:0] ctrl_word;
	logic [31:0] wmask;

	// Config decode
	always_comb begin
		// RULE9 config default off
		sw_en  = ~switch_monitor_config_i[1];
		// RULE8 config decode
		mon_en = sw_en & ~switch_monitor_config_i[0];
	end

	// Control register image
	always_comb begin
		ctrl_word = 32'h0;
		ctrl_word[POS_CUR_LO +: 3]  = r.cur_sel;
		ctrl_word[POS_NEXT_LO +: 3] = r.next_sel;
		ctrl_word[POS_FAIL_FLAG]    = r.fail_flag;
		// RULE11 request reads zero
		ctrl_word[POS_REQUEST]      = r.request & sw_en;
	end

	assign low_power_rc_osc_tick = r.low_power_rc_osc_sync[1] & ~r.low_power_rc_osc_sync[2];
	assign mon_edge  = r.mon_sync[1] ^ r.mon_sync[2];
	assign bus_hit   = wb_req_i.cyc & wb_req_i.stb & ~r.rsp.ack;
	assign wr_ok     = bus_hit & wb_req_i.we;
	assign wmask     = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
	                    {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

	// Next state
	always_comb begin
		next_r = r;
		next_r.rsp.ack = bus_hit;
		next_r.rsp.dat = 32'h0;
		next_r.low_power_rc_osc_sync = {r.low_power_rc_osc_sync[1:0], low_power_rc_osc_i};
		next_r.mon_sync  = {r.mon_sync[1:0], primary_osc_i};

		// Boot load of selection
		if (!r.booted) begin
			next_r.booted   = 1'b1;
			next_r.cur_sel  = default_osc_config_i;
			next_r.next_sel = default_osc_config_i;
			next_r.osc_en   = 6'h01 << default_osc_config_i;
		end

		// RULE10 selection from config
		if (!sw_en) begin
			next_r.cur_sel = default_osc_config_i;
			next_r.request = 1'b0;
		end

		// Register reads
		if (bus_hit && !wb_req_i.we) begin
			if (wb_req_i.adr == ADDR_OSC_CONTROL) begin
				next_r.rsp.dat = ctrl_word;
			end else if (wb_req_i.adr == ADDR_IRQ_CONFIG) begin
				next_r.rsp.dat[POS_IRQ_EN] = r.irq_enable;
				next_r.rsp.dat[POS_PRIO_LO +: 3] = r.prio;
				next_r.rsp.dat[POS_SUBPRIO_LO +: 2] = r.subprio;
			end else if (wb_req_i.adr == ADDR_STATUS) begin
				next_r.rsp.dat[0] = r.irq_flag;
				next_r.rsp.dat[1] = (r.key == KEY_OPEN);
				next_r.rsp.dat[2] = r.mon_armed;
			end
		end

		// Key register writes
		if (wr_ok && wb_req_i.adr == ADDR_UNLOCK_KEY) begin
			// RULE18 two key unlock
			if (r.key == KEY_HALF && wb_req_i.dat == KEY_SECOND) begin
				next_r.key = KEY_OPEN;
			end else if (wb_req_i.dat == KEY_FIRST) begin
				next_r.key = KEY_HALF;
			end else begin
				// RULE19 non key relocks
				next_r.key = KEY_LOCKED;
			end
		end else if (bus_hit && r.key == KEY_HALF) begin
			// RULE27 broken pair resets detector
			next_r.key = KEY_LOCKED;
		end

		// RULE25 lock held until relock
		if (wr_ok && wb_req_i.adr == ADDR_OSC_CONTROL && r.key == KEY_OPEN) begin
			if (wb_req_i.sel[1]) begin
				next_r.next_sel = wb_req_i.dat[POS_NEXT_LO +: 3];
			end
			// RULE11 request ignored when off
			if (wb_req_i.sel[0] && sw_en && wb_req_i.dat[POS_REQUEST]) begin
				next_r.request = 1'b1;
			end
			if (wb_req_i.sel[0] && !wb_req_i.dat[POS_FAIL_FLAG]) begin
				next_r.fail_flag = 1'b0;
			end
		end

		// Interrupt config writes
		if (wr_ok && wb_req_i.adr == ADDR_IRQ_CONFIG) begin
			if (wmask[POS_IRQ_EN]) begin
				next_r.irq_enable = wb_req_i.dat[POS_IRQ_EN];
			end
			// RULE6 priority fields
			if (wb_req_i.sel[1]) begin
				next_r.prio    = wb_req_i.dat[POS_PRIO_LO +: 3];
				next_r.subprio = wb_req_i.dat[POS_SUBPRIO_LO +: 2];
			end
		end
		if (wr_ok && wb_req_i.adr == ADDR_STATUS && wb_req_i.sel[0] && wb_req_i.dat[0]) begin
			next_r.irq_flag = 1'b0;
		end

		// Switch sequencer
		case (r.sw)
			SW_IDLE: begin
				if (r.request && sw_en) begin
					// RULE20 redundant switch aborted
					if (r.next_sel == r.cur_sel) begin
						next_r.request = 1'b0;
					// RULE16 PLL to PLL refused
					end else if (is_pll(r.next_sel) && is_pll(r.cur_sel)) begin
						next_r.request = 1'b0;
					end else begin
						// RULE21 enable target source
						next_r.osc_en[r.next_sel] = 1'b1;
						next_r.sw = SW_WAIT_READY;
					end
				end
			end
			SW_WAIT_READY: begin
				// RULE24 wait while source absent; RULE21 ready, plus lock for PLL targets
				if (osc_ready_i[r.next_sel] && (!is_pll(r.next_sel) || pll_lock_status_i)) begin
					next_r.sw = SW_DONE;
				end
			end
			SW_DONE: begin
				// RULE22 complete switch
				next_r.osc_en[r.cur_sel] = 1'b0;
				next_r.osc_en[r.next_sel] = 1'b1;
				next_r.cur_sel = r.next_sel;
				next_r.request = 1'b0;
				next_r.sw = SW_IDLE;
			end
			default: begin
				next_r.sw = SW_IDLE;
			end
		endcase

		// RULE23 sleep aborts switch
		if (sleep_i && r.sw != SW_IDLE) begin
			next_r.sw = SW_IDLE;
			next_r.request = 1'b0;
			next_r.osc_en[r.next_sel] = (r.next_sel == r.cur_sel);
		end

		// RULE12 start delay on wake
		if (wake_i) begin
			next_r.mon_armed = 1'b0;
			next_r.delay_cnt = needs_delay(r.cur_sel) ? 4'(START_DELAY_TICKS) : 4'h0;
		end else if (!r.mon_armed) begin
			// RULE13 wait for running source
			if (primary_running_i && low_power_rc_osc_tick) begin
				if (r.delay_cnt == 4'h0) begin
					next_r.mon_armed = 1'b1;
					next_r.win_cnt = 4'h0;
					next_r.seen_edge = 1'b0;
				end else begin
					next_r.delay_cnt = r.delay_cnt - 4'h1;
				end
			end
		end

		// RULE14 window on low power RC
		if (r.mon_armed) begin
			if (mon_edge) begin
				next_r.seen_edge = 1'b1;
			end
			if (low_power_rc_osc_tick) begin
				if (r.win_cnt == 4'(MON_WINDOW_TICKS - 1)) begin
					next_r.win_cnt = 4'h0;
					next_r.seen_edge = mon_edge;
					// RULE26 no edge in window
					if (!r.seen_edge && !mon_edge && mon_en &&
					    (r.cur_sel == SRC_PRIMARY || r.cur_sel == SRC_PRIMARY_PLL)) begin
						// RULE1 fall back to fast RC
						next_r.cur_sel = SRC_FAST_RC;
						// RULE2 select shows fast RC
						next_r.osc_en[SRC_FAST_RC] = 1'b1;
						// RULE3 set clock fail flag
						next_r.fail_flag = 1'b1;
						// RULE4 cancel pending switch
						next_r.request = 1'b0;
						next_r.sw = SW_IDLE;
						// RULE5 event independent of enable
						next_r.irq_flag = 1'b1;
						// RULE7 stays until reset or switch
						next_r.mon_armed = 1'b0;
					end
				end else begin
					next_r.win_cnt = r.win_cnt + 4'h1;
				end
			end
		end

		// Registered interrupt line from next flag and enable
		next_r.irq_line = next_r.irq_flag & next_r.irq_enable;
	end

	// State register
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			r <= '0;
			r.sw <= SW_IDLE;
			r.key <= KEY_LOCKED;
			r.delay_cnt <= 4'(START_DELAY_TICKS);
		end else begin
			r <= next_r;
		end
	end

	// RULE15 submode fixed outside this block
	assign wb_rsp_o          = r.rsp;
	assign current_osc_sel_o = r.cur_sel;
	assign osc_enable_o      = r.osc_en;
	assign fail_irq_flag_o   = r.irq_flag;
	assign fail_irq_o        = r.irq_line;
endmodule : csfm_core

// *** tb/csfm_core_assertions.sv ***
`timescale 1ns/1ps
// ====================
// Port checks
module csfm_core_assertions (
	input wire logic                     sys_clk_i,
	input wire logic                     rst_n_i,
	input wire csfm_pkg::csfm_wb_req_type wb_req_i,
	input wire csfm_pkg::csfm_wb_rsp_type wb_rsp_o,
	input wire logic [1:0]               switch_monitor_config_i,
	input wire logic [2:0]               default_osc_config_i,
	input wire logic [2:0]               current_osc_sel_o,
	input wire logic                     fail_irq_o,
	input wire logic                     fail_irq_flag_o
);
	import csfm_pkg::*;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Request taken
	sequence s_take;
		wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
	endsequence
	property p_ack; s_take |=> wb_rsp_o.ack; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack1; wb_rsp_o.ack |=> !wb_rsp_o.ack; endproperty
	a_ack1: assert property (p_ack1) else $error("ack too long");
	property p_unmap;
		s_take ##0 (!wb_req_i.we && wb_req_i.adr == 8'h10) |=> wb_rsp_o.dat == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped data");
	property p_irq; fail_irq_o |-> fail_irq_flag_o; endproperty
	a_irq: assert property (p_irq) else $error("irq without flag");
	property p_fall; $rose(fail_irq_flag_o) |-> current_osc_sel_o == SRC_FAST_RC; endproperty
	a_fall: assert property (p_fall) else $error("no fallback");
	property p_off;
		$past(rst_n_i) && switch_monitor_config_i[1] |-> current_osc_sel_o == default_osc_config_i;
	endproperty
	a_off: assert property (p_off) else $error("off mode source");
	property p_nomon; switch_monitor_config_i == 2'b01 |-> !$rose(fail_irq_flag_o); endproperty
	a_nomon: assert property (p_nomon) else $error("monitor in 01");
	property p_nomon_off; switch_monitor_config_i[1] |-> !$rose(fail_irq_flag_o); endproperty
	a_nomon_off: assert property (p_nomon_off) else $error("monitor off");
	property p_stick;
		fail_irq_flag_o && !(wb_req_i.cyc && wb_req_i.we && wb_req_i.adr == ADDR_STATUS)
			|=> fail_irq_flag_o;
	endproperty
	a_stick: assert property (p_stick) else $error("flag lost");
endmodule : csfm_core_assertions

// *** tb/csfm_core_test.sv ***
`timescale 1ns/1ps
// ====================
// Bench top
module csfm_core_test;
	import csfm_pkg::*;
	logic            sys_clk = 1'b0;
	logic            rst_n = 1'b0;
	csfm_wb_req_type req = '0;
	csfm_wb_rsp_type rsp;
	logic [1:0]      cfg = 2'b00;
	logic [2:0]      dflt = SRC_PRIMARY;
	logic            low_power_rc_osc = 1'b0;
	logic            primary_osc = 1'b0;
	logic            on = 1'b1;
	logic [5:0]      rdy = 6'h3f;
	logic [3:0]      cnt = 4'h0;
	logic            run = 1'b1;
	logic            lock = 1'b1;
	logic            slp = 1'b0;
	logic            wk = 1'b0;
	logic [2:0]      cur;
	logic [5:0]      oen;
	logic            irq;
	logic            irqf;
	logic [31:0]     q;
	int              error_cnt = 0;
	int              num_checks = 0;
	// Clock
	always #20 sys_clk = ~sys_clk;
	// Slow tick and primary activity
	always @(posedge sys_clk) begin
		cnt <= cnt + 4'h1;
		low_power_rc_osc <= cnt[3];
		if (on)
			primary_osc <= ~primary_osc;
	end
	csfm_core csfm_core_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .wb_req_i(req),
		.wb_rsp_o(rsp), .switch_monitor_config_i(cfg), .default_osc_config_i(dflt),
		.low_power_rc_osc_i(low_power_rc_osc), .primary_osc_i(primary_osc), .primary_running_i(run),
		.osc_ready_i(rdy), .pll_lock_status_i(lock), .sleep_i(slp), .wake_i(wk),
		.current_osc_sel_o(cur), .osc_enable_o(oen), .fail_irq_o(irq),
		.fail_irq_flag_o(irqf));
	task wrap_up;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
		@(posedge sys_clk);
		while (rsp.ack !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		chk(32'(rsp.ack), 32'h1);
		q = rsp.dat;
		req <= '0;
		@(posedge sys_clk);
	endtask : bus
	task key;
		bus(1'b1, ADDR_UNLOCK_KEY, KEY_FIRST);
		bus(1'b1, ADDR_UNLOCK_KEY, KEY_SECOND);
	endtask : key
	task wcur(input logic [2:0] v);
		int n;
		n = 0;
		while (cur !== v && n < 500) begin
			@(posedge sys_clk);
			n++;
		end
		chk(32'(cur), 32'(v));
	endtask : wcur
	task rst(input logic [1:0] c, input logic [2:0] d);
		cfg <= c;
		dflt <= d;
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask : rst
	task idle;
		repeat (20) @(posedge sys_clk);
	endtask : idle
	task t_lock;
		wcur(SRC_PRIMARY);
		bus(1'b1, ADDR_OSC_CONTROL, 32'h401);
		idle;
		chk(32'(cur), 32'(SRC_PRIMARY));
		bus(1'b0, 8'h10, 32'h0);
		chk(q, 32'h0);
	endtask : t_lock
	task t_switch;
		key;
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(q & 32'h2, 32'h2);
		bus(1'b1, ADDR_OSC_CONTROL, 32'h401);
		wcur(SRC_SECONDARY);
		chk(32'(oen & 6'h14), 32'h10);
		bus(1'b0, ADDR_OSC_CONTROL, 32'h0);
		chk(q & 32'h7701, 32'h4400);
		bus(1'b1, ADDR_OSC_CONTROL, 32'h401);
		idle;
		bus(1'b0, ADDR_OSC_CONTROL, 32'h0);
		chk(q & 32'h1, 32'h0);
		bus(1'b1, ADDR_OSC_CONTROL, 32'h201);
		wcur(SRC_PRIMARY);
		bus(1'b1, ADDR_UNLOCK_KEY, 32'h12345678);
		bus(1'b1, ADDR_OSC_CONTROL, 32'h401);
		idle;
		chk(32'(cur), 32'(SRC_PRIMARY));
	endtask : t_switch
	task t_fail;
		bus(1'b1, ADDR_IRQ_CONFIG, 32'h5600);
		bus(1'b0, ADDR_IRQ_CONFIG, 32'h0);
		chk(q & 32'h7f00, 32'h5600);
		key;
		rdy <= 6'h2f;
		bus(1'b1, ADDR_OSC_CONTROL, 32'h401);
		idle;
		bus(1'b0, ADDR_OSC_CONTROL, 32'h0);
		chk(q & 32'h7001, 32'h2001);
		on <= 1'b0;
		wcur(SRC_FAST_RC);
		chk(32'(irq), 32'h1);
		bus(1'b0, ADDR_OSC_CONTROL, 32'h0);
		chk(q & 32'h7009, 32'h0008);
		bus(1'b1, ADDR_STATUS, 32'h1);
		chk(32'(irqf), 32'h0);
		on <= 1'b1;
		rdy <= 6'h3f;
		repeat (100) @(posedge sys_clk);
		chk(32'(cur), 32'(SRC_FAST_RC));
	endtask : t_fail
	task t_quiet;
		rst(2'b01, SRC_PRIMARY);
		on <= 1'b0;
		repeat (300) @(posedge sys_clk);
		chk(32'(cur), 32'(SRC_PRIMARY));
		key;
		bus(1'b1, ADDR_OSC_CONTROL, 32'h001);
		wcur(SRC_FAST_RC);
		on <= 1'b1;
	endtask : t_quiet
	task t_off;
		rst(2'b10, SRC_SECONDARY);
		wcur(SRC_SECONDARY);
		key;
		bus(1'b1, ADDR_OSC_CONTROL, 32'h101);
		bus(1'b0, ADDR_OSC_CONTROL, 32'h0);
		chk(q & 32'h1, 32'h0);
		idle;
		chk(32'(cur), 32'(SRC_SECONDARY));
	endtask : t_off
	// PLL lock wait, refusal, sleep and wake
	task t_pll;
		rst(2'b00, SRC_FAST_RC);
		wcur(SRC_FAST_RC);
		key;
		lock <= 1'b0;
		bus(1'b1, ADDR_OSC_CONTROL, 32'h301);
		idle;
		chk(32'(cur), 32'(SRC_FAST_RC));
		lock <= 1'b1;
		wcur(SRC_PRIMARY_PLL);
		wk <= 1'b1;
		run <= 1'b0;
		@(posedge sys_clk);
		wk <= 1'b0;
		repeat (200) @(posedge sys_clk);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(q & 32'h4, 32'h0);
		run <= 1'b1;
		repeat (60) @(posedge sys_clk);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(q & 32'h4, 32'h0);
		repeat (200) @(posedge sys_clk);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(q & 32'h4, 32'h4);
		bus(1'b1, ADDR_OSC_CONTROL, 32'h101);
		idle;
		bus(1'b0, ADDR_OSC_CONTROL, 32'h0);
		chk(q & 32'h7001, 32'h3000);
		rdy <= 6'h2f;
		bus(1'b1, ADDR_OSC_CONTROL, 32'h401);
		slp <= 1'b1;
		idle;
		slp <= 1'b0;
		rdy <= 6'h3f;
		bus(1'b0, ADDR_OSC_CONTROL, 32'h0);
		chk(q & 32'h7001, 32'h3000);
	endtask : t_pll
	// Main sequence
	initial begin
		rst(2'b00, SRC_PRIMARY);
		t_lock;
		t_switch;
		t_fail;
		t_quiet;
		t_off;
		t_pll;
		wrap_up;
	end
	// Watchdog
	initial begin
		#2000000;
		error_cnt++;
		wrap_up;
	end
endmodule : csfm_core_test
bind csfm_core csfm_core_assertions csfm_core_assertions_i (.sys_clk_i, .rst_n_i, .wb_req_i,
	.wb_rsp_o, .switch_monitor_config_i, .default_osc_config_i, .current_osc_sel_o,
	.fail_irq_o, .fail_irq_flag_o);
